// ---- p5g_port.v ----
// Purpose: 8-pin port with wake-up inputs and segment sharing
// Assumes: pad inputs asynchronous, all else on mclk
// Notes:   pad outputs, enables and pull-ups are registered
//          subsleep freezes the pads; registers stay writable
//
// What this block does
// [R1] output-direction bits read back latch value
// [R2] input-direction bits read sampled pin level
// [R3] direction bit per pin: 1 out
// [R4] direction register write-only, reads all ones
// [R5] latch, direction drive the pad only in plain I/O
// [R6] pull-up on: direction 0, enable 1
// [R7] pull-ups off right after reset
// [R8] six bus registers reset to zero
// [R9] wake select bit picks I/O or wake
// [R10] segment beats wake select beats direction
// [R11] segment ranges: upper 2-9, lower 1-8
// [R12] reset/standby float, subsleep holds, else run
// [R13] standby pull-up pins present high
// [R14] wake pins forward synchronised low request
`include "p5g_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module p5g_port #(
    parameter NPIN = 8
) (
    input  wire            mclk,
    input  wire            rstn,
    input  wire [15:0]     bus_addr,
    input  wire [7:0]      bus_wdata,
    input  wire            bus_wr,
    input  wire            bus_rd,
    output reg  [7:0]      bus_rdata,
    input  wire [3:0]      segment_select_field,
    input  wire [NPIN-1:0] lcd_segment_output,
    input  wire            mode_subsleep,
    input  wire            mode_standby,
    input  wire [NPIN-1:0] port_pin_in,
    output reg  [NPIN-1:0] port_pin_out,
    output reg  [NPIN-1:0] port_pin_oe,
    output reg  [NPIN-1:0] port_pin_pullup,
    output reg  [NPIN-1:0] wake_req,
    output reg             irq
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg  [NPIN-1:0] port_output_data_r;
    reg  [NPIN-1:0] port_direction_r;
    reg  [NPIN-1:0] port_pullup_enable_r;
    reg  [NPIN-1:0] pin_function_select_r;
    reg  [NPIN-1:0] wake_stat_r;
    reg  [NPIN-1:0] wake_mask_r;
    reg  [NPIN-1:0] sync1_r;
    reg  [NPIN-1:0] sync2_r;
    reg  [NPIN-1:0] sync3_r;
    reg  [NPIN-1:0] pin_lvl_r;
    reg  [NPIN-1:0] wake_prev_r;
    reg  [NPIN-1:0] wake_stat_nxt;
    reg  [7:0]      rd_nxt;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire hit_func = (bus_addr == `P5G_ADR_FUNC);
    wire hit_data = (bus_addr == `P5G_ADR_DATA);
    wire hit_pull = (bus_addr == `P5G_ADR_PULL);
    wire hit_dir  = (bus_addr == `P5G_ADR_DIR);
    wire hit_stat = (bus_addr == `P5G_ADR_STAT);
    wire hit_mask = (bus_addr == `P5G_ADR_MASK);

    // one write strobe per register
    wire wr_func  = bus_wr & hit_func;
    wire wr_data  = bus_wr & hit_data;
    wire wr_pull  = bus_wr & hit_pull;
    wire wr_dir   = bus_wr & hit_dir;
    wire wr_stat  = bus_wr & hit_stat;
    wire wr_mask  = bus_wr & hit_mask;

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    // output data latch
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            port_output_data_r <= `P5G_RST8; // R8
        end else if (wr_data) begin
            port_output_data_r <= bus_wdata;
        end
    end

    // direction, one bit per pin
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            port_direction_r <= `P5G_RST8; // R8
        end else if (wr_dir) begin
            port_direction_r <= bus_wdata; // R3
        end
    end

    // pull-up enables
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            port_pullup_enable_r <= `P5G_RST8; // R8
        end else if (wr_pull) begin
            port_pullup_enable_r <= bus_wdata;
        end
    end

    // wake select bits
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_function_select_r <= `P5G_RST8; // R8
        end else if (wr_func) begin
            pin_function_select_r <= bus_wdata;
        end
    end

    // wake interrupt mask
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wake_mask_r <= `P5G_RST8;
        end else if (wr_mask) begin
            wake_mask_r <= bus_wdata;
        end
    end

    // ----------------------------------------
    // pad input synchroniser
    // ----------------------------------------
    // stages reset high, like an idle pulled-up pin
    // first stage, only the second stage reads it
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= `P5G_ONES8;
        end else begin
            sync1_r <= port_pin_in;
        end
    end

    // second stage
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync2_r <= `P5G_ONES8;
        end else begin
            sync2_r <= sync1_r;
        end
    end

    // third stage
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync3_r <= `P5G_ONES8;
        end else begin
            sync3_r <= sync2_r;
        end
    end

    // a bit changes only once stages 2 and 3 agree
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_lvl_r <= `P5G_ONES8;
        end else begin
            pin_lvl_r <= (sync2_r & ~(sync2_r ^ sync3_r))
                       | (pin_lvl_r & (sync2_r ^ sync3_r));
        end
    end

    // ----------------------------------------
    // pin function decode
    // ----------------------------------------
    wire seg_hi = (segment_select_field >= `P5G_SEG_HI_LO) &&
                  (segment_select_field <= `P5G_SEG_HI_HI); // R11
    wire seg_lo = (segment_select_field >= `P5G_SEG_LO_LO) &&
                  (segment_select_field <= `P5G_SEG_LO_HI); // R11
    wire [NPIN-1:0] seg_claim = {{4{seg_hi}}, {4{seg_lo}}};
    wire [NPIN-1:0] wake_sel  = ~seg_claim
                              & pin_function_select_r; // R9 R10
    wire [NPIN-1:0] gpio_sel  = ~seg_claim
                              & ~pin_function_select_r; // R5 R9
    wire [NPIN-1:0] gpio_out  = gpio_sel & port_direction_r; // R3 R5
    // pull-up on input-direction pins with enable set; a segment pin drives
    wire [NPIN-1:0] pu_on     = ~seg_claim & ~port_direction_r
                              & port_pullup_enable_r; // R6
    wire [NPIN-1:0] out_nxt   = (seg_claim & lcd_segment_output)
                              | (gpio_out & port_output_data_r); // R10
    wire [NPIN-1:0] oe_nxt    = seg_claim | gpio_out; // R10
    wire [NPIN-1:0] wake_low  = wake_sel & ~pin_lvl_r;

    // ----------------------------------------
    // pad drive by operating mode
    // ----------------------------------------
    localparam [1:0] PAD_RUN  = 2'b00;
    localparam [1:0] PAD_STBY = 2'b01;
    localparam [1:0] PAD_HOLD = 2'b10;

    // subsleep outranks standby
    wire [1:0] pad_mode = mode_subsleep ? PAD_HOLD
                        : mode_standby  ? PAD_STBY
                        : PAD_RUN;

    // pad drive value
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            port_pin_out <= `P5G_ZERO8; // R12
        end else begin
            case (pad_mode)
                PAD_RUN: begin
                    port_pin_out <= out_nxt; // R10
                end
                PAD_STBY: begin
                    port_pin_out <= `P5G_ZERO8; // R12
                end
                PAD_HOLD: begin
                    port_pin_out <= port_pin_out; // R12
                end
                default: begin
                    port_pin_out <= `P5G_ZERO8;
                end
            endcase
        end
    end

    // pad drive enable
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            port_pin_oe <= `P5G_ZERO8; // R12
        end else begin
            case (pad_mode)
                PAD_RUN: begin
                    port_pin_oe <= oe_nxt; // R10
                end
                PAD_STBY: begin
                    port_pin_oe <= `P5G_ZERO8; // R12
                end
                PAD_HOLD: begin
                    port_pin_oe <= port_pin_oe; // R12
                end
                default: begin
                    port_pin_oe <= `P5G_ZERO8;
                end
            endcase
        end
    end

    // pull-up control, kept in standby so the pad reads high
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            port_pin_pullup <= `P5G_ZERO8; // R7
        end else begin
            case (pad_mode)
                PAD_RUN: begin
                    port_pin_pullup <= pu_on; // R6
                end
                PAD_STBY: begin
                    port_pin_pullup <= pu_on; // R13
                end
                PAD_HOLD: begin
                    port_pin_pullup <= port_pin_pullup; // R12
                end
                default: begin
                    port_pin_pullup <= `P5G_ZERO8;
                end
            endcase
        end
    end

    // ----------------------------------------
    // wake requests and interrupt
    // ----------------------------------------
    // request level per wake pin
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wake_req <= `P5G_ZERO8;
        end else begin
            wake_req <= wake_low; // R14
        end
    end

    // previous request level, for edge detect
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wake_prev_r <= `P5G_ZERO8;
        end else begin
            wake_prev_r <= wake_low;
        end
    end

    // new falling edge wins over a clear
    always @* begin
        wake_stat_nxt = wake_stat_r;
        if (wr_stat) begin
            wake_stat_nxt = wake_stat_nxt & ~bus_wdata;
        end
        wake_stat_nxt = wake_stat_nxt | (wake_low & ~wake_prev_r);
    end

    // sticky wake status
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wake_stat_r <= `P5G_ZERO8;
        end else begin
            wake_stat_r <= wake_stat_nxt;
        end
    end

    // level interrupt from unmasked status
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(wake_stat_r & wake_mask_r);
        end
    end

    // ----------------------------------------
    // read back
    // ----------------------------------------
    // unmapped addresses read zero
    always @* begin
        rd_nxt = `P5G_ZERO8;
        case (bus_addr)
            `P5G_ADR_DATA: begin
                rd_nxt = (port_direction_r & port_output_data_r)
                       | (~port_direction_r & pin_lvl_r); // R1 R2
            end
            `P5G_ADR_DIR: begin
                rd_nxt = `P5G_ONES8; // R4
            end
            `P5G_ADR_PULL: begin
                rd_nxt = port_pullup_enable_r;
            end
            `P5G_ADR_FUNC: begin
                rd_nxt = pin_function_select_r;
            end
            `P5G_ADR_STAT: begin
                rd_nxt = wake_stat_r;
            end
            `P5G_ADR_MASK: begin
                rd_nxt = wake_mask_r;
            end
            default: begin
                rd_nxt = `P5G_ZERO8;
            end
        endcase
    end

    // read data stands one cycle, else zero
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bus_rdata <= `P5G_ZERO8;
        end else if (bus_rd) begin
            bus_rdata <= rd_nxt;
        end else begin
            bus_rdata <= `P5G_ZERO8;
        end
    end

endmodule

`default_nettype wire

// ---- p5g_consts.vh ----
// Purpose: constants of the port 5 pin block
// Assumes: byte-wide register port, 16-bit addresses
// Notes:   definitions only
`ifndef P5G_CONSTS_VH
`define P5G_CONSTS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define P5G_ADR_FUNC   16'hffcc
`define P5G_ADR_DATA   16'hffd8
`define P5G_ADR_PULL   16'hffe2
`define P5G_ADR_DIR    16'hffe8
`define P5G_ADR_STAT   16'hffce
`define P5G_ADR_MASK   16'hffcf

// ----------------------------------------
// values
// ----------------------------------------
`define P5G_RST8       8'h00
`define P5G_ONES8      8'hff
`define P5G_ZERO8      8'h00

// ----------------------------------------
// segment-select ranges
// ----------------------------------------
`define P5G_SEG_HI_LO  4'h2
`define P5G_SEG_HI_HI  4'h9
`define P5G_SEG_LO_LO  4'h1
`define P5G_SEG_LO_HI  4'h8

`endif

// ---- p5g_port_chk.sv ----
// Purpose: assertions on the port 5 pin block
// Assumes: one clock, async active-low reset
// Notes:   bound to p5g_port
`timescale 1ns/100ps
`default_nettype none
module p5g_port_chk #(
    parameter NPIN = 8
) (
    input wire logic            mclk,
    input wire logic            rstn,
    input wire logic [15:0]     bus_addr,
    input wire logic [7:0]      bus_wdata,
    input wire logic            bus_wr,
    input wire logic            bus_rd,
    input wire logic [7:0]      bus_rdata,
    input wire logic [3:0]      segment_select_field,
    input wire logic [NPIN-1:0] lcd_segment_output,
    input wire logic            mode_subsleep,
    input wire logic            mode_standby,
    input wire logic [NPIN-1:0] port_pin_in,
    input wire logic [NPIN-1:0] port_pin_out,
    input wire logic [NPIN-1:0] port_pin_oe,
    input wire logic [NPIN-1:0] port_pin_pullup,
    input wire logic [NPIN-1:0] wake_req,
    input wire logic            irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire run = !mode_subsleep && !mode_standby;
    sequence s_up;
        segment_select_field >= 4'h2 && segment_select_field <= 4'h9 && run;
    endsequence
    sequence s_lo;
        segment_select_field >= 4'h1 && segment_select_field <= 4'h8 && run;
    endsequence
    a_dir_ones: assert property (
        bus_rd && bus_addr == 16'hffe8 |=> bus_rdata == 8'hff)
        else $error("direction read not all ones");
    a_rd_idle: assert property (!bus_rd |=> bus_rdata == 8'h00)
        else $error("read data without read");
    a_rd_unmapped: assert property (
        bus_rd && bus_addr == 16'hffd0 |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_seg_upper: assert property (s_up |=> port_pin_oe[7:4] == 4'hf &&
        port_pin_out[7:4] == $past(lcd_segment_output[7:4]))
        else $error("upper segment claim wrong");
    a_seg_lower: assert property (s_lo |=> port_pin_oe[3:0] == 4'hf &&
        port_pin_out[3:0] == $past(lcd_segment_output[3:0]))
        else $error("lower segment claim wrong");
    a_standby_float: assert property (
        mode_standby && !mode_subsleep |=> port_pin_oe == 8'h00)
        else $error("pad driven in standby");
    a_subsleep_hold: assert property (mode_subsleep |=>
        $stable(port_pin_oe) && $stable(port_pin_out) && $stable(port_pin_pullup))
        else $error("pads moved in subsleep");
    a_rst_quiet: assert property (disable iff (1'b0)
        !rstn |-> port_pin_oe == 8'h00 && port_pin_pullup == 8'h00)
        else $error("pads active in reset");
endmodule
bind p5g_port p5g_port_chk #(.NPIN(NPIN)) u_chk (.mclk(mclk), .rstn(rstn),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .mode_standby(mode_standby),
    .segment_select_field(segment_select_field), .irq(irq),
    .lcd_segment_output(lcd_segment_output), .mode_subsleep(mode_subsleep),
    .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
    .port_pin_oe(port_pin_oe), .port_pin_pullup(port_pin_pullup),
    .wake_req(wake_req));
`default_nettype wire

// ---- p5g_port_tb_top.sv ----
// Purpose: self-checking bench of the port 5 pin block
// Assumes: pads resolved here from drive, pull-up and external level
// Notes:   register rows first, then hand-written mode cases
`timescale 1ns/100ps
`default_nettype none
module p5g_port_tb_top;
    logic        mclk, rstn, bus_wr, bus_rd, mode_subsleep, mode_standby;
    logic [15:0] bus_addr;
    logic [7:0]  bus_wdata, lcd, ext, claim;
    logic [3:0]  field;
    wire  [7:0]  rdata, out, oe, pu, wk, pad;
    wire         irq;
    int          n_errors, samples_checked, cyc;
    // addr, write, value after reset, value after write
    logic [39:0] rows [0:6] = '{{16'hffcc, 8'h5a, 8'h00, 8'h5a},
        {16'hffe2, 8'h3c, 8'h00, 8'h3c}, {16'hffe8, 8'h0f, 8'hff, 8'hff},
        {16'hffd8, 8'ha5, 8'h96, 8'hb5}, {16'hffce, 8'h00, 8'h00, 8'h48},
        {16'hffcf, 8'h48, 8'h00, 8'h48}, {16'hffd0, 8'h77, 8'h00, 8'h00}};
    assign pad = (oe & out) | (~oe & (pu | ext));
    p5g_port DUT (.mclk(mclk), .rstn(rstn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(rdata), .segment_select_field(field),
        .lcd_segment_output(lcd), .mode_subsleep(mode_subsleep),
        .mode_standby(mode_standby), .port_pin_in(pad), .port_pin_out(out),
        .port_pin_oe(oe), .port_pin_pullup(pu), .wake_req(wk), .irq(irq));
    task chk(input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk) {bus_addr, bus_wdata, bus_wr} <= {a, d, 1'b1};
        @(posedge mclk) bus_wr <= 1'b0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk) {bus_addr, bus_rd} <= {a, 1'b1};
        @(posedge mclk) bus_rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task finish_test;
        if (n_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            finish_test;
        end
    end
    initial begin
        {rstn, bus_wr, bus_rd, mode_subsleep, mode_standby} = 5'h00;
        {bus_addr, bus_wdata, lcd, ext, field} = {16'h0000, 8'h00, 8'hc3,
            8'h96, 4'h0};
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        chk(oe | pu, 8'h00);
        repeat (6) @(posedge mclk);
        foreach (rows[i]) rd(rows[i][39:24], rows[i][15:8]);
        foreach (rows[i]) begin
            wr(rows[i][39:24], rows[i][23:16]);
            repeat (6) @(posedge mclk);
            rd(rows[i][39:24], rows[i][7:0]);
        end
        chk(oe, 8'h05);
        chk(pu, 8'h30);
        chk(wk, 8'h48);
        chk({7'h00, irq}, 8'h01);
        wr(16'hffce, 8'h48);
        repeat (3) @(posedge mclk);
        chk({7'h00, irq}, 8'h00);
        for (int f = 0; f < 16; f++) begin
            field <= f[3:0];
            repeat (3) @(posedge mclk);
            claim = {{4{f >= 2 && f <= 9}}, {4{f >= 1 && f <= 8}}};
            chk(oe, claim | (8'h05 & ~claim));
            chk(out & claim, lcd & claim);
        end
        field <= 4'h0;
        mode_standby <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(oe, 8'h00);
        chk(pu, 8'h30);
        {mode_standby, mode_subsleep} <= 2'b01;
        wr(16'hffe8, 8'hff);
        repeat (3) @(posedge mclk);
        chk(oe, 8'h00);
        mode_subsleep <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(oe, 8'ha5);
        finish_test;
    end
endmodule
`default_nettype wire
